/* hw/ddrpd_pkg.sv */
// Purpose: shared constants and types of the power-down and termination block
// Assumes: byte addresses on the register bus, one 32-bit word per register
// Notes: latency defaults are counted in command-clock cycles
package ddrpd_pkg;

  // register byte offsets
  localparam logic [7:0] ADR_MODE = 8'h00;
  localparam logic [7:0] ADR_STAT = 8'h04;
  localparam logic [7:0] ADR_LAT = 8'h08;

  // mode register fields
  localparam int MODE_DLL_KEEP = 0;
  localparam int MODE_NOM_LSB = 1;
  localparam int MODE_WR_LSB = 4;
  localparam int MODE_W = 6;
  localparam logic [5:0] MODE_RST = 6'h00;

  // status register fields
  localparam int STAT_PD_ACT = 0;
  localparam int STAT_PD_PRE = 1;
  localparam int STAT_DLL = 2;
  localparam int STAT_RTT = 3;
  localparam int STAT_CA_RCV = 4;
  localparam int STAT_IO_BUF = 5;
  localparam int STAT_RESET = 6;

  // latency defaults in command-clock cycles
  localparam logic [3:0] CWL_DEF = 4'h5;
  localparam logic [3:0] AL_DEF = 4'h0;
  localparam logic [3:0] CPDED_DEF = 4'h1;
  localparam logic [3:0] ODTL_OFS = 4'h2;
  localparam int DLY_DEPTH = 16;
  localparam int RTT_LANES = 6;

  // pin vector layout: ck, cke, odt, cs, ras, cas, we, reset
  localparam int PIN_CK = 7;
  localparam int PIN_CKE = 6;
  localparam int PIN_ODT = 5;
  localparam int PIN_CS = 4;
  localparam int PIN_RAS = 3;
  localparam int PIN_CAS = 2;
  localparam int PIN_WE = 1;
  localparam int PIN_RST = 0;
  localparam logic [7:0] PIN_RST_VAL = 8'h1F;

  typedef enum logic [2:0] {
    ST_UP,
    ST_ENTRY,
    ST_ACT_PD,
    ST_PRE_PD,
    ST_RESET
  } ddrpd_state_t;

endpackage : ddrpd_pkg

/* hw/ddrpd_odt_dly.sv */
// Purpose: posted termination delay line stepped by command-clock edges
// Assumes: step is a one-cycle pulse per command-clock rising edge
// Notes: tap n gives the pin level sampled n command edges earlier
`timescale 1ns/1ps
module ddrpd_odt_dly (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clr,
  input wire logic step,
  input wire logic din,
  input wire logic [3:0] tap_sel,
  output logic dout
);

  logic [ddrpd_pkg::DLY_DEPTH-1:0] sh_q;
  logic [ddrpd_pkg::DLY_DEPTH-1:0] sh_d;

  always_comb begin
    sh_d = sh_q;
    if (clr) begin
      sh_d = '0;
    end else if (step) begin
      sh_d = {sh_q[ddrpd_pkg::DLY_DEPTH-2:0], din};
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sh_q <= '0;
    end else begin
      sh_q <= sh_d;
    end
  end

  assign dout = sh_q[tap_sel];

endmodule : ddrpd_odt_dly

/* hw/ddrpd_top.sv */
// Purpose: power-down state keeping and on-die termination control
// Assumes: command clock arrives as a pin, sampled by SYS_CLK
// Notes: registers reached over classic Wishbone
//
// How it works
// RULE_01 - enter power-down at a clock edge with CKE low and NOP or deselect
// RULE_02 - controller keeps CKE high while MRS, MPR, ZQ, DLL lock or data busy
// RULE_03 - after in-flight work ends: all banks closed precharge, else active
// RULE_04 - controller resets DLL after exit if DLL was unlocked at entry
// RULE_05 - power-down gates all buffers except clock, ODT, CKE and reset
// RULE_06 - command receivers stay on until tCPDED passes after entry
// RULE_07 - precharge power-down with A12 low stops DLL; otherwise DLL stays on
// RULE_08 - controller waits tXP, or tXPDLL for reads and ODT after slow exit
// RULE_09 - controller holds CKE low, reset high, clock and ODT valid
// RULE_10 - reset pin low during power-down forces immediate exit to reset
// RULE_11 - controller holds CKE low tCKE, stays at most nine refresh intervals
// RULE_12 - CKE high with NOP or deselect exits; controller honours tCKE, tXP
// RULE_13 - one ODT input switches termination on every x16 lane together
// RULE_14 - ODT pin ignored in self-refresh and when mode bits disable it
// RULE_15 - termination enabled when any nominal or write resistance bit set
// RULE_16 - termination follows only the ODT level, never command decode
// RULE_17 - synchronous termination timing whenever the DLL runs
// RULE_18 - controller disables termination while DLL is off
// RULE_19 - termination switches CWL plus AL minus 2 clocks after sampling
// RULE_20 - controller holds ODT high ODTH4, or ODTH8 after 8-beat write; the controller model enforces only ODTH4
// RULE_21 - controller drops ODT before read preamble, restores after postamble
// RULE_22 - termination returns only after read drivers release the data lines
// RULE_23 - ODTH4 is 4 clocks and ODTH8 is 6 clocks
// RULE_24 - latencies are parameters counted in whole clock cycles
//
// The Wishbone slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module ddrpd_top #(
  parameter logic [3:0] P_CWL = ddrpd_pkg::CWL_DEF,
  parameter logic [3:0] P_AL = ddrpd_pkg::AL_DEF,
  parameter logic [3:0] P_CPDED = ddrpd_pkg::CPDED_DEF
) (
  input wire logic SYS_CLK,
  input wire logic RST_B,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic CK,
  input wire logic CKE,
  input wire logic ODT,
  input wire logic CS_B,
  input wire logic RAS_B,
  input wire logic CAS_B,
  input wire logic WE_B,
  input wire logic MEM_RESET_B,
  input wire logic CORE_BUSY,
  input wire logic BANKS_OPEN,
  input wire logic SELF_REFRESH,
  input wire logic RD_DRIVING,
  output logic PD_ACTIVE,
  output logic PD_PRECHARGE,
  output logic DLL_EN,
  output logic CA_RCV_EN,
  output logic IO_BUF_EN,
  output logic DEV_RESET,
  output logic [5:0] RTT_EN,
  output logic [2:0] RTT_NOM_SEL,
  output logic [1:0] RTT_WR_SEL
);

  // nop or deselect on the sampled command pins
  function automatic logic is_nop(input logic [7:0] p);
    is_nop = p[ddrpd_pkg::PIN_CS] ||
             (p[ddrpd_pkg::PIN_RAS] && p[ddrpd_pkg::PIN_CAS] && p[ddrpd_pkg::PIN_WE]);
  endfunction : is_nop

  // register index from byte address, 3 means unmapped
  function automatic logic [1:0] reg_idx(input logic [7:0] adr);
    unique case (adr)
      ddrpd_pkg::ADR_MODE: reg_idx = 2'h0;
      ddrpd_pkg::ADR_STAT: reg_idx = 2'h1;
      ddrpd_pkg::ADR_LAT: reg_idx = 2'h2;
      default: reg_idx = 2'h3;
    endcase
  endfunction : reg_idx

  // pin synchroniser, two stages, then a copy for edge finding
  logic [7:0] pins_raw;
  logic [7:0] sync1_q;
  logic [7:0] sync2_q;
  logic [7:0] prev_q;
  logic [7:0] sync1_d;
  logic [7:0] sync2_d;
  logic [7:0] prev_d;

  assign pins_raw = {CK, CKE, ODT, CS_B, RAS_B, CAS_B, WE_B, MEM_RESET_B};

  always_comb begin
    sync1_d = pins_raw;
    sync2_d = sync1_q;
    prev_d = sync2_q;
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      sync1_q <= ddrpd_pkg::PIN_RST_VAL;
      sync2_q <= ddrpd_pkg::PIN_RST_VAL;
      prev_q <= ddrpd_pkg::PIN_RST_VAL;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      prev_q <= prev_d;
    end
  end

  // CKE, ODT and command pins are taken from the cycle before the edge is seen, so a controller
  // changing them just after its clock edge cannot race the sample
  logic ck_rise;
  logic cke_s;
  logic odt_s;
  logic nop_s;
  logic rst_pin;
  logic enter_ev;
  logic exit_ev;

  assign ck_rise = sync2_q[ddrpd_pkg::PIN_CK] && !prev_q[ddrpd_pkg::PIN_CK];
  assign cke_s = prev_q[ddrpd_pkg::PIN_CKE];
  assign odt_s = prev_q[ddrpd_pkg::PIN_ODT];
  assign nop_s = is_nop(prev_q);
  assign rst_pin = sync2_q[ddrpd_pkg::PIN_RST];
  assign enter_ev = ck_rise && !cke_s && nop_s; // RULE_01
  assign exit_ev = ck_rise && cke_s && nop_s; // RULE_12

  // power-down state machine
  ddrpd_pkg::ddrpd_state_t st_q;
  ddrpd_pkg::ddrpd_state_t st_d;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    if (!rst_pin) begin
      st_d = ddrpd_pkg::ST_RESET; // RULE_10
      cnt_d = 4'h0;
    end else begin
      unique case (st_q)
        ddrpd_pkg::ST_RESET: begin
          st_d = ddrpd_pkg::ST_UP;
        end
        ddrpd_pkg::ST_UP: begin
          if (enter_ev) begin
            st_d = ddrpd_pkg::ST_ENTRY; // RULE_01
            cnt_d = P_CPDED; // RULE_06
          end
        end
        ddrpd_pkg::ST_ENTRY: begin
          if (exit_ev) begin
            st_d = ddrpd_pkg::ST_UP;
          end else begin
            if (ck_rise && cnt_q != 4'h0) begin
              cnt_d = cnt_q - 4'h1; // RULE_06
            end
            // pending activates or refreshes finish before the mode settles
            if (cnt_q == 4'h0 && !CORE_BUSY) begin
              st_d = BANKS_OPEN ? ddrpd_pkg::ST_ACT_PD : ddrpd_pkg::ST_PRE_PD; // RULE_03
            end
          end
        end
        ddrpd_pkg::ST_ACT_PD, ddrpd_pkg::ST_PRE_PD: begin
          if (exit_ev) begin
            st_d = ddrpd_pkg::ST_UP; // RULE_12
          end
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      st_q <= ddrpd_pkg::ST_RESET;
      cnt_q <= 4'h0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
    end
  end

  // mode register and bus slave
  logic [5:0] mode_q;
  logic [5:0] mode_d;
  logic ack_q;
  logic ack_d;
  logic [31:0] dat_q;
  logic [31:0] dat_d;
  logic [31:0] stat_w;
  logic [1:0] idx;
  logic req;

  assign req = WB_CYC_I && WB_STB_I && !ack_q;
  assign idx = reg_idx(WB_ADR_I);
  assign stat_w = {25'h0, DEV_RESET, IO_BUF_EN, CA_RCV_EN, RTT_EN[0],
                   DLL_EN, PD_PRECHARGE, PD_ACTIVE};

  always_comb begin
    mode_d = mode_q;
    ack_d = req;
    dat_d = 32'h00000000;
    // the write lands at the edge where the master samples ack high
    if (WB_CYC_I && WB_STB_I && ack_q && WB_WE_I && idx == 2'h0 && WB_SEL_I[0]) begin
      mode_d = WB_DAT_I[ddrpd_pkg::MODE_W-1:0];
    end
    if (req && !WB_WE_I) begin
      unique case (idx)
        2'h0: dat_d = {26'h0, mode_q};
        2'h1: dat_d = stat_w;
        2'h2: dat_d = {24'h000000, P_AL, P_CWL};
        2'h3: dat_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      mode_q <= ddrpd_pkg::MODE_RST;
      ack_q <= 1'b0;
      dat_q <= 32'h00000000;
    end else begin
      mode_q <= mode_d;
      ack_q <= ack_d;
      dat_q <= dat_d;
    end
  end

  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = dat_q;

  // termination path
  logic [3:0] odtl;
  logic dly_tap;
  logic mr_en;
  logic [2:0] nom_f;
  logic [1:0] wr_f;

  assign odtl = P_CWL + P_AL - ddrpd_pkg::ODTL_OFS; // RULE_19 RULE_24
  assign nom_f = mode_q[ddrpd_pkg::MODE_NOM_LSB +: 3];
  assign wr_f = mode_q[ddrpd_pkg::MODE_WR_LSB +: 2];
  assign mr_en = (nom_f != 3'h0) || (wr_f != 2'h0); // RULE_15

  // only the pin level enters the line; command decode never does
  ddrpd_odt_dly u_dly (
    .clk(SYS_CLK),
    .rst_b(RST_B),
    .clr(st_q == ddrpd_pkg::ST_RESET),
    .step(ck_rise),
    .din(odt_s), // RULE_16
    .tap_sel(odtl),
    .dout(dly_tap)
  );

  // output flops, state outputs derived from the next state, resistance selects from mode_q
  logic pd_act_d;
  logic pd_pre_d;
  logic dll_d;
  logic ca_d;
  logic io_d;
  logic rst_o_d;
  logic rtt_d;

  always_comb begin
    pd_act_d = st_d == ddrpd_pkg::ST_ACT_PD;
    pd_pre_d = st_d == ddrpd_pkg::ST_PRE_PD;
    // slow exit only from precharge power-down with the keep bit clear
    dll_d = st_d != ddrpd_pkg::ST_RESET &&
            !(pd_pre_d && !mode_q[ddrpd_pkg::MODE_DLL_KEEP]); // RULE_07
    ca_d = st_d == ddrpd_pkg::ST_UP || st_d == ddrpd_pkg::ST_ENTRY; // RULE_06
    io_d = st_d == ddrpd_pkg::ST_UP; // RULE_05
    rst_o_d = st_d == ddrpd_pkg::ST_RESET; // RULE_10
    // no async mode: with the DLL stopped termination simply stays off
    rtt_d = dly_tap && mr_en && dll_d && !SELF_REFRESH && // RULE_14 RULE_17
            !RD_DRIVING && !rst_o_d; // RULE_22
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      PD_ACTIVE <= 1'b0;
      PD_PRECHARGE <= 1'b0;
      DLL_EN <= 1'b0;
      CA_RCV_EN <= 1'b0;
      IO_BUF_EN <= 1'b0;
      DEV_RESET <= 1'b1;
      RTT_NOM_SEL <= 3'h0;
      RTT_WR_SEL <= 2'h0;
    end else begin
      PD_ACTIVE <= pd_act_d;
      PD_PRECHARGE <= pd_pre_d;
      DLL_EN <= dll_d;
      CA_RCV_EN <= ca_d;
      IO_BUF_EN <= io_d;
      DEV_RESET <= rst_o_d;
      RTT_NOM_SEL <= nom_f; // RULE_15
      RTT_WR_SEL <= wr_f;
    end
  end

  // one flop per lane, all fed from the same termination decision
  for (genvar g = 0; g < ddrpd_pkg::RTT_LANES; g++) begin : g_lane
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
        RTT_EN[g] <= 1'b0;
      end else begin
        RTT_EN[g] <= rtt_d; // RULE_13
      end
    end
  end

  // checks
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_B);

  sequence s_in_pd;
    st_q == ddrpd_pkg::ST_ACT_PD || st_q == ddrpd_pkg::ST_PRE_PD;
  endsequence

  sequence s_wake;
    exit_ev && rst_pin;
  endsequence

  sequence s_enter;
    st_q == ddrpd_pkg::ST_UP && enter_ev && rst_pin;
  endsequence

  pd_entry_a: assert property ( // RULE_01
    s_enter |=> st_q == ddrpd_pkg::ST_ENTRY && CA_RCV_EN && !IO_BUF_EN)
    else $error("power-down not entered on cke low with nop");

  settle_act_a: assert property ( // RULE_03
    st_q == ddrpd_pkg::ST_ENTRY && cnt_q == 4'h0 && !CORE_BUSY && BANKS_OPEN &&
    rst_pin && !exit_ev |=> PD_ACTIVE && !PD_PRECHARGE)
    else $error("open bank did not give active power-down");

  settle_pre_a: assert property ( // RULE_03
    st_q == ddrpd_pkg::ST_ENTRY && cnt_q == 4'h0 && !CORE_BUSY && !BANKS_OPEN &&
    rst_pin && !exit_ev |=> PD_PRECHARGE && !PD_ACTIVE)
    else $error("closed banks did not give precharge power-down");

  buf_gate_a: assert property ( // RULE_05
    (PD_ACTIVE || PD_PRECHARGE) |-> !IO_BUF_EN && !CA_RCV_EN)
    else $error("buffers left on in power-down");

  rcv_hold_a: assert property ( // RULE_06
    $fell(CA_RCV_EN) && $past(rst_pin) |->
    $past(st_q) == ddrpd_pkg::ST_ENTRY && $past(cnt_q) == 4'h0)
    else $error("receivers off before tCPDED");

  dll_slow_a: assert property ( // RULE_07
    PD_PRECHARGE && !$past(mode_q[ddrpd_pkg::MODE_DLL_KEEP]) |-> !DLL_EN)
    else $error("dll running in slow-exit power-down");

  dll_fast_a: assert property ( // RULE_07
    PD_ACTIVE |-> DLL_EN)
    else $error("dll stopped in active power-down");

  reset_exit_a: assert property ( // RULE_10
    !rst_pin |=> DEV_RESET && !PD_ACTIVE && !PD_PRECHARGE && !RTT_EN[0])
    else $error("reset pin did not force reset state");

  pd_wake_a: assert property ( // RULE_12
    s_in_pd ##0 s_wake |=> IO_BUF_EN ##1 (IO_BUF_EN || !$past(rst_pin)))
    else $error("power-down not left on cke high");

  lane_tie_a: assert property ( // RULE_13
    RTT_EN == {ddrpd_pkg::RTT_LANES{RTT_EN[0]}})
    else $error("lanes differ in termination");

  sr_off_a: assert property ( // RULE_14
    $past(SELF_REFRESH) |-> RTT_EN == 6'h00)
    else $error("termination on in self-refresh");

  mr_off_a: assert property ( // RULE_15
    !$past(mr_en) |-> RTT_EN == 6'h00)
    else $error("termination on with resistance fields zero");

  pin_only_a: assert property ( // RULE_16
    $rose(RTT_EN[0]) |-> $past(dly_tap))
    else $error("termination rose without posted pin level");

  sync_pd_a: assert property ( // RULE_17
    PD_ACTIVE && $past(dly_tap) && $past(mr_en) && !$past(SELF_REFRESH) &&
    !$past(RD_DRIVING) |-> RTT_EN[0])
    else $error("termination not applied in active power-down");

  post_step_a: assert property ( // RULE_19
    $changed(dly_tap) |-> $past(ck_rise) || $past(st_q) == ddrpd_pkg::ST_RESET)
    else $error("posted termination moved without a clock edge");

  rd_gap_a: assert property ( // RULE_22
    $past(RD_DRIVING) |-> !RTT_EN[0])
    else $error("termination on while drivers active");

endmodule : ddrpd_top

/* verif/ddrpd_ctrl_model.sv */
// Purpose: memory controller stand-in for clock, CKE, ODT, reset and command pins
// Assumes: eight SYS_CLK ticks per command clock, so CK has an 800 ns period
// Notes: pins move only at CK fall, well away from the device's sampling edge
`timescale 1ns/1ps
module ddrpd_ctrl_model #(
  parameter int P_TCKE = 3,
  parameter int P_ODTH4 = 4,
  parameter int P_TXPDLL = 10
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic want_cke,
  input wire logic want_odt,
  input wire logic [3:0] want_cmd,
  input wire logic want_rst_b,
  output logic CK,
  output logic CKE,
  output logic ODT,
  output logic [3:0] cmd_pins,
  output logic MEM_RESET_B
);
  logic [2:0] ph;
  int cke_age;
  int odt_age;
  // clock runs free: it must stay stable through power-down
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ph <= 3'h0;
      CK <= 1'b0;
      CKE <= 1'b1;
      ODT <= 1'b0;
      cmd_pins <= 4'h7;
      MEM_RESET_B <= 1'b1;
      cke_age <= 0;
      odt_age <= 0;
    end else begin
      ph <= ph + 3'h1;
      if (ph == 3'h7) begin
        CK <= 1'b1;
        cke_age <= cke_age + 1;
        odt_age <= odt_age + 1;
      end
      if (ph == 3'h3) begin
        CK <= 1'b0;
        cmd_pins <= want_cmd;
        MEM_RESET_B <= want_rst_b;
        // entry always finds the dll locked, so no dll reset is owed after exit
        if (want_cke != CKE && cke_age >= P_TCKE) begin
          CKE <= want_cke;
          cke_age <= 0;
        end
        // an early drop request is simply deferred, never cut short
        // odt moves only with cke high and tXPDLL past the last exit
        if (want_odt != ODT && CKE && cke_age >= P_TXPDLL &&
            (!ODT || odt_age >= P_ODTH4)) begin
          ODT <= want_odt;
          odt_age <= 0;
        end
      end
    end
  end
endmodule : ddrpd_ctrl_model

/* verif/tb.sv */
// Purpose: self-checking bench for power-down and termination control
// Assumes: controller model drives the memory pins, bench drives the bus
// Notes: additive latency set to 2 so the posted delay is not the default
`timescale 1ns/1ps
module tb;
  localparam logic [3:0] TB_CWL = ddrpd_pkg::CWL_DEF;
  localparam logic [3:0] TB_AL = 4'h2;
  localparam int ODTL = int'(TB_CWL) + int'(TB_AL) - int'(ddrpd_pkg::ODTL_OFS);
  logic SYS_CLK = 1'b0;
  logic RST_B = 1'b0;
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'h0;
  logic [3:0] sel_use = 4'hF;
  logic [31:0] wb_dat = 32'h0, wb_rdat;
  logic ck, cke, odt, mem_rst_b, pd_act, pd_pre, dll_en, ca_en, io_en, dev_rst;
  logic [3:0] cmd;
  logic core_busy = 1'b0, banks_open = 1'b0, self_ref = 1'b0, rd_drv = 1'b0;
  logic want_cke = 1'b1, want_odt = 1'b0, want_rst_b = 1'b1;
  logic [3:0] want_cmd = 4'h7;
  logic [5:0] rtt;
  logic [2:0] nom_sel;
  logic [1:0] wr_sel;
  int num_errors = 0;
  int n_checks = 0;

  always #50 SYS_CLK = ~SYS_CLK;

  ddrpd_top #(.P_CWL(TB_CWL), .P_AL(TB_AL), .P_CPDED(ddrpd_pkg::CPDED_DEF)) i_ddrpd_top (
    .SYS_CLK(SYS_CLK), .RST_B(RST_B), .WB_CYC_I(wb_cyc), .WB_STB_I(wb_stb),
    .WB_WE_I(wb_we), .WB_ADR_I(wb_adr), .WB_SEL_I(wb_sel), .WB_DAT_I(wb_dat),
    .WB_DAT_O(wb_rdat), .WB_ACK_O(wb_ack), .CK(ck), .CKE(cke), .ODT(odt),
    .CS_B(cmd[3]), .RAS_B(cmd[2]), .CAS_B(cmd[1]), .WE_B(cmd[0]), .MEM_RESET_B(mem_rst_b),
    .CORE_BUSY(core_busy), .BANKS_OPEN(banks_open), .SELF_REFRESH(self_ref),
    .RD_DRIVING(rd_drv), .PD_ACTIVE(pd_act), .PD_PRECHARGE(pd_pre), .DLL_EN(dll_en),
    .CA_RCV_EN(ca_en), .IO_BUF_EN(io_en), .DEV_RESET(dev_rst), .RTT_EN(rtt),
    .RTT_NOM_SEL(nom_sel), .RTT_WR_SEL(wr_sel));

  ddrpd_ctrl_model i_ddrpd_ctrl_model (
    .clk(SYS_CLK), .rst_b(RST_B), .want_cke(want_cke), .want_odt(want_odt),
    .want_cmd(want_cmd), .want_rst_b(want_rst_b), .CK(ck), .CKE(cke), .ODT(odt),
    .cmd_pins(cmd), .MEM_RESET_B(mem_rst_b));

  task automatic tally_and_finish();
    if (num_errors == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [5:0] probe(input int sel);
    case (sel)
      0: return {5'h0, pd_act};
      1: return {5'h0, pd_pre};
      2: return {5'h0, io_en};
      3: return {5'h0, dev_rst};
      4: return rtt;
      5: return {5'h0, cke};
      default: return {5'h0, odt};
    endcase
  endfunction : probe

  // bounded wait; running out counts as a mismatch and ends the run
  task automatic wait_for(input int sel, input logic [5:0] exp, output int n);
    for (n = 0; n < 400 && probe(sel) !== exp; n++) @(posedge SYS_CLK);
    chk(probe(sel), exp);
    if (n == 400) tally_and_finish();
  endtask : wait_for

  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d,
                    output logic [31:0] q);
    int i;
    @(posedge SYS_CLK);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_dat <= d;
    wb_sel <= sel_use;
    for (i = 0; i < 20 && wb_ack !== 1'b1; i++) @(posedge SYS_CLK);
    q = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (i == 20) begin
      chk(1'b0, 1'b1);
      tally_and_finish();
    end
  endtask : wb

  task automatic set_pins(input logic c, input logic o, input logic [3:0] m, input logic r);
    @(posedge SYS_CLK);
    want_cke <= c;
    want_odt <= o;
    want_cmd <= m;
    want_rst_b <= r;
  endtask : set_pins

  initial begin
    repeat (90000) @(posedge SYS_CLK);
    chk(1'b0, 1'b1);
    tally_and_finish();
  end

  initial begin
    int n;
    logic [31:0] q;
    logic [5:0] m;
    n = $urandom(46);
    repeat (10) @(posedge SYS_CLK);
    RST_B <= 1'b1;
    repeat (3) @(posedge SYS_CLK);
    chk({pd_act, pd_pre, dll_en, ca_en, io_en, dev_rst, rtt}, 12'h380);
    wb(1'b0, ddrpd_pkg::ADR_MODE, 32'h0, q);
    chk(q, 32'h0);
    wb(1'b0, ddrpd_pkg::ADR_LAT, 32'h0, q);
    chk(q, {24'h0, TB_AL, TB_CWL});
    wb(1'b1, ddrpd_pkg::ADR_STAT, $urandom, q);
    wb(1'b0, ddrpd_pkg::ADR_STAT, 32'h0, q);
    chk(q, 32'h34);
    wb(1'b1, 8'hFC, $urandom, q);
    wb(1'b0, 8'hFC, 32'h0, q);
    chk(q, 32'h0);
    // low byte lane disabled: the mode write must be dropped
    sel_use = 4'hE;
    wb(1'b1, ddrpd_pkg::ADR_MODE, $urandom | 32'h0000003F, q);
    sel_use = 4'hF;
    wb(1'b0, ddrpd_pkg::ADR_MODE, 32'h0, q);
    chk(q, 32'h0);
    // CKE low beside an activate must not power down
    set_pins(1'b0, 1'b0, 4'h3, 1'b1);
    repeat (48) @(posedge SYS_CLK);
    chk(io_en, 1'b1);
    set_pins(1'b1, 1'b0, 4'h7, 1'b1);
    wait_for(5, 6'h01, n);
    banks_open <= 1'b1;
    core_busy <= 1'b1;
    set_pins(1'b0, 1'b0, 4'h7, 1'b1);
    wait_for(2, 6'h00, n);
    repeat (48) @(posedge SYS_CLK);
    chk({pd_act, pd_pre, ca_en}, 3'b001);
    core_busy <= 1'b0;
    wait_for(0, 6'h01, n);
    chk({dll_en, ca_en, io_en}, 3'b100);
    set_pins(1'b1, 1'b0, 4'h7, 1'b1);
    wait_for(2, 6'h01, n);
    repeat (2) @(posedge SYS_CLK);
    chk({pd_act, ca_en}, 2'b01);
    banks_open <= 1'b0;
    for (int j = 0; j < 2; j++) begin
      wb(1'b1, ddrpd_pkg::ADR_MODE, j, q);
      set_pins(1'b0, 1'b0, 4'h7, 1'b1);
      wait_for(1, 6'h01, n);
      chk(dll_en, j[0]);
      set_pins(1'b1, 1'b0, 4'h7, j[0] ? 1'b0 : 1'b1);
      if (j == 1) begin
        wait_for(3, 6'h01, n);
        chk({pd_pre, rtt}, 7'h00);
        set_pins(1'b1, 1'b0, 4'h7, 1'b1);
        wait_for(3, 6'h00, n);
      end
      wait_for(2, 6'h01, n);
    end
    for (int j = 0; j < 4; j++) begin
      m = (j == 0) ? 6'h10 : 6'($urandom);
      if (m[5:1] == 5'h0) m[2] = 1'b1;
      wb(1'b1, ddrpd_pkg::ADR_MODE, {26'h0, m}, q);
      wb(1'b0, ddrpd_pkg::ADR_MODE, 32'h0, q);
      chk(q, {26'h0, m});
      chk({nom_sel, wr_sel}, {m[3:1], m[5:4]});
      set_pins(1'b1, 1'b1, 4'h7, 1'b1);
      wait_for(6, 6'h01, n);
      @(posedge ck);
      wait_for(4, 6'h3F, n);
      chk(n >= 8 * ODTL && n < 8 * ODTL + 8, 1'b1);
      // a write with ODT high obliges an eight-beat hold, so stay long
      set_pins(1'b1, 1'b1, 4'h4, 1'b1);
      repeat (56) @(posedge SYS_CLK);
      chk(rtt, 6'h3F);
      set_pins(1'b1, 1'b0, 4'h7, 1'b1);
      wait_for(6, 6'h00, n);
      @(posedge ck);
      wait_for(4, 6'h00, n);
      chk(n >= 8 * ODTL && n < 8 * ODTL + 8, 1'b1);
    end
    set_pins(1'b1, 1'b1, 4'h7, 1'b1);
    wait_for(4, 6'h3F, n);
    self_ref <= 1'b1;
    wait_for(4, 6'h00, n);
    self_ref <= 1'b0;
    wait_for(4, 6'h3F, n);
    // odt goes low before the read, then returns while drivers still run
    set_pins(1'b1, 1'b0, 4'h7, 1'b1);
    wait_for(4, 6'h00, n);
    rd_drv <= 1'b1;
    set_pins(1'b1, 1'b1, 4'h7, 1'b1);
    repeat (8 * ODTL + 24) @(posedge SYS_CLK);
    chk(rtt, 6'h00);
    rd_drv <= 1'b0;
    wait_for(4, 6'h3F, n);
    wb(1'b1, ddrpd_pkg::ADR_MODE, 32'h0, q);
    wait_for(4, 6'h00, n);
    set_pins(1'b1, 1'b0, 4'h7, 1'b1);
    tally_and_finish();
  end
endmodule : tb
